//--- sdam_mapper.sv
// Package of shared constants and the row/column address mapper
package sdam_pkg;
    localparam int HOST_AW = 28;              // 256 MByte decode space
    localparam int MA_W = 11;                 // Dedicated memory address lines
    localparam int FULL_MA_W = 13;            // Address incl. lines borrowed from chip selects
    localparam int BANK_W = 2;
    localparam int MAX_BANKS_SMALL = 4;       // 16 Mbit parts
    localparam int MAX_BANKS_DENSE = 2;       // 64 Mbit and denser parts
    localparam int DATA_W = 64;               // Bank width
    localparam int COL_LO = 3;                // Host bits 2..0 select a byte in the 64-bit word
    localparam int BA0_BIT = 11;
    localparam int BA1_BIT = 12;
    localparam logic [4:0] SPAN_16M = 5'h19;  // Bank size as log2 bytes
    localparam logic [4:0] SPAN_64_2B = 5'h1B;
    localparam logic [4:0] SPAN_64_4B = 5'h1C;
    localparam logic [4:0] SPAN_256 = 5'h1C;
    localparam logic [3:0] CS_IDLE = 4'hF;

    // Part density and internal bank organisation
    typedef enum logic [1:0] {
        SDAM_D16 = 2'b00,
        SDAM_D64_2B = 2'b01,
        SDAM_D64_4B = 2'b10,
        SDAM_D256 = 2'b11
    } sdam_density_t;

    // Sequencer states
    typedef enum logic [1:0] {
        SDAM_IDLE = 2'b00,
        SDAM_ROW = 2'b01,
        SDAM_COL = 2'b10
    } sdam_state_t;
endpackage

`timescale 1ns/10ps
// Combinational host to row/column translation
module sdam_mapper (
    // Request
    input wire logic [sdam_pkg::HOST_AW-1:0] host_addr_in,
    input wire sdam_pkg::sdam_density_t density_in,
    input wire logic col_phase_in,
    // Mapped address
    output logic [sdam_pkg::FULL_MA_W-1:0] ma_out,
    output logic ba0_out,
    output logic ba1_out
);
    import sdam_pkg::*;

    logic [HOST_AW-1:0] a;
    assign a = host_addr_in;

    // Bank selects come from the same host bits in both phases
    always_comb begin
        ba0_out = a[BA0_BIT];
        ba1_out = (density_in == SDAM_D64_4B || density_in == SDAM_D256) ? a[BA1_BIT] : 1'b0;
        ma_out = '0;
        case (density_in)
            SDAM_D16: begin
                if (col_phase_in) begin
                    ma_out = {3'h0, a[24], a[23], a[10:COL_LO]};
                end else begin
                    ma_out = {2'h0, a[22:12]};
                end
            end
            SDAM_D64_2B: begin
                if (col_phase_in) begin
                    ma_out = {3'h0, a[26], a[25], a[10:COL_LO]};
                end else begin
                    ma_out = a[24:12];
                end
            end
            SDAM_D64_4B: begin
                if (col_phase_in) begin
                    ma_out = {1'b0, a[27], 1'b0, a[26], a[25], a[10:COL_LO]};
                end else begin
                    ma_out = {1'b0, a[24:13]};
                end
            end
            default: begin
                if (col_phase_in) begin
                    ma_out = {3'h0, a[27], a[26], a[10:COL_LO]};
                end else begin
                    ma_out = a[25:13];
                end
            end
        endcase
    end
endmodule

//--- sdam_ctrl.sv
// SDRAM address mapper top: bank decode, pin reuse and row/column sequencing
// Functional notes
// - Host addresses decode a main memory space of at most 256 MByte.
// - Every bank is 64 bits wide; narrower organisations are not supported.
// - With 16 Mbit parts up to four banks are decoded, each with its own chip select.
// - With 64, 128 or 256 Mbit parts at most two banks decode; the third select becomes bit 11, the fourth bit 12 or, with 64/128 Mbit four-bank, bank select 1.
// - Host memory is decoded contiguously from zero to the end of the populated capacity.
// - Bank select 0 sits on the line used as bit 11 for 16 Mbit parts and bit 13 for 64/128 Mbit two-bank parts.
// - 16 Mbit row phase: bank select 0 from host bit 11, address 10..0 from host 22..12.
// - 16 Mbit column phase: bank select 0 from bit 11, bit 10 zero, bits 9..8 from 24..23, bits 7..0 from 10..3.
// - 64/128 Mbit two-bank row phase: bank select 0 from bit 11, address 12..0 from host 24..12.
// - 64/128 Mbit column: bits 9..8 from 26..25, 7..0 from 10..3, bit 10 zero, bit 11 from 27 with four banks.
// - 64/128 Mbit four-bank row phase: bank selects from bits 11 and 12, address 11..0 from host 24..13.
// - 256 Mbit: row selects 11 and 12, address 25..13; column 12..10 zero, 9..8 from 27..26, 7..0 from 10..3.
`timescale 1ns/10ps
module sdam_ctrl #(
    parameter int HOST_ADDR_W = sdam_pkg::HOST_AW,
    parameter int BANK_DATA_W = sdam_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Configuration
    input wire sdam_pkg::sdam_density_t density_in,
    input wire logic [2:0] banks_fitted_in,
    // Host request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [sdam_pkg::HOST_AW-1:0] req_addr_in,
    output logic req_ready_out,
    output logic req_err_out,
    // Memory side
    output logic [sdam_pkg::MA_W-1:0] memory_address_bus_out,
    output logic internal_bank_select_0_out,
    output logic internal_bank_select_1_out,
    output logic [1:0] chip_select_n_out,
    output logic third_chip_select_n_out,
    output logic fourth_chip_select_n_out,
    output logic cmd_activate_out,
    output logic cmd_read_out,
    output logic cmd_write_out
);
    import sdam_pkg::*;

    // Only the documented geometry is served
    if (HOST_ADDR_W != HOST_AW) begin : g_bad_aw
        $error("sdam_ctrl: host address width must be 28");
    end
    if (BANK_DATA_W != DATA_W) begin : g_bad_dw
        $error("sdam_ctrl: banks must be 64 bits wide");
    end

    typedef struct packed {
        sdam_state_t state;
        logic [HOST_AW-1:0] addr;
        logic write;
        logic [BANK_W-1:0] bank;
        logic [FULL_MA_W-1:0] ma;
        logic ba0;
        logic ba1;
        logic [3:0] cs_n;
        logic act;
        logic rd;
        logic wr;
        logic err;
    } sdam_regs_t;

    sdam_regs_t cur_ff;
    sdam_regs_t nxt_cur;

    logic map_col;
    logic [HOST_AW-1:0] map_addr;
    logic [FULL_MA_W-1:0] map_ma;
    logic map_ba0;
    logic map_ba1;

    // Bank size as log2 bytes for a density
    function automatic logic [4:0] span_of(input sdam_density_t d);
        case (d)
            SDAM_D16: span_of = SPAN_16M;
            SDAM_D64_2B: span_of = SPAN_64_2B;
            SDAM_D64_4B: span_of = SPAN_64_4B;
            default: span_of = SPAN_256;
        endcase
    endfunction

    // Number of banks that decode, bank zero always counted
    function automatic logic [2:0] banks_used(input sdam_density_t d, input logic [2:0] fitted);
        logic [2:0] lim;
        lim = (d == SDAM_D16) ? 3'(MAX_BANKS_SMALL) : 3'(MAX_BANKS_DENSE);
        if (fitted == 3'h0) begin
            banks_used = 3'h1;
        end else if (fitted > lim) begin
            banks_used = lim;
        end else begin
            banks_used = fitted;
        end
    endfunction

    // Row address on acceptance, column address while the row phase stands
    assign map_col = (cur_ff.state == SDAM_ROW);
    assign map_addr = (cur_ff.state == SDAM_IDLE) ? req_addr_in : cur_ff.addr;

    sdam_mapper u_mapper (
        .host_addr_in(map_addr),
        .density_in(density_in),
        .col_phase_in(map_col),
        .ma_out(map_ma),
        .ba0_out(map_ba0),
        .ba1_out(map_ba1)
    );

    logic [HOST_AW-1:0] bank_idx;
    logic in_range;

    // Contiguous decode: bank index is the address above one bank's span
    always_comb begin
        bank_idx = req_addr_in >> span_of(density_in);
        in_range = (bank_idx < HOST_AW'(banks_used(density_in, banks_fitted_in)));
    end

    // Next-state logic
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.act = 1'b0;
        nxt_cur.rd = 1'b0;
        nxt_cur.wr = 1'b0;
        nxt_cur.err = 1'b0;
        case (cur_ff.state)
            SDAM_IDLE: begin
                nxt_cur.ma = '0;
                nxt_cur.ba0 = 1'b0;
                nxt_cur.ba1 = 1'b0;
                nxt_cur.cs_n = CS_IDLE;
                if (req_valid_in) begin
                    if (in_range) begin
                        nxt_cur.state = SDAM_ROW;
                        nxt_cur.addr = req_addr_in;
                        nxt_cur.write = req_write_in;
                        nxt_cur.bank = bank_idx[BANK_W-1:0];
                        nxt_cur.ma = map_ma;
                        nxt_cur.ba0 = map_ba0;
                        nxt_cur.ba1 = map_ba1;
                        nxt_cur.cs_n = ~(4'h1 << bank_idx[BANK_W-1:0]);
                        nxt_cur.act = 1'b1;
                    end else begin
                        nxt_cur.err = 1'b1;
                    end
                end
            end
            SDAM_ROW: begin
                nxt_cur.state = SDAM_COL;
                nxt_cur.ma = map_ma;
                nxt_cur.ba0 = map_ba0;
                nxt_cur.ba1 = map_ba1;
                nxt_cur.rd = ~cur_ff.write;
                nxt_cur.wr = cur_ff.write;
            end
            default: begin
                nxt_cur.state = SDAM_IDLE;
                nxt_cur.ma = '0;
                nxt_cur.ba0 = 1'b0;
                nxt_cur.ba1 = 1'b0;
                nxt_cur.cs_n = CS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            cur_ff <= '{state: SDAM_IDLE, cs_n: CS_IDLE, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Pin assignment; dense parts borrow the upper two chip selects
    always_comb begin
        req_ready_out = (cur_ff.state == SDAM_IDLE);
        req_err_out = cur_ff.err;
        memory_address_bus_out = cur_ff.ma[MA_W-1:0];
        internal_bank_select_0_out = cur_ff.ba0;
        internal_bank_select_1_out = cur_ff.ba1;
        chip_select_n_out = cur_ff.cs_n[1:0];
        cmd_activate_out = cur_ff.act;
        cmd_read_out = cur_ff.rd;
        cmd_write_out = cur_ff.wr;
        if (density_in == SDAM_D16) begin
            third_chip_select_n_out = cur_ff.cs_n[2];
            fourth_chip_select_n_out = cur_ff.cs_n[3];
        end else begin
            third_chip_select_n_out = cur_ff.ma[MA_W];
            if (density_in == SDAM_D64_4B) begin
                fourth_chip_select_n_out = cur_ff.ba1;
            end else begin
                fourth_chip_select_n_out = cur_ff.ma[MA_W+1];
            end
        end
    end
endmodule

//--- sdam_checker_props.sv
// Port-level checks on the SDRAM address mapper
`timescale 1ns/10ps
module sdam_checker
    import sdam_pkg::*;
(
    // Clock, reset and request
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire sdam_pkg::sdam_density_t density_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [sdam_pkg::HOST_AW-1:0] req_addr_in,
    input wire logic req_ready_out,
    input wire logic req_err_out,
    // Memory side
    input wire logic [sdam_pkg::MA_W-1:0] memory_address_bus_out,
    input wire logic internal_bank_select_0_out,
    input wire logic internal_bank_select_1_out,
    input wire logic [1:0] chip_select_n_out,
    input wire logic fourth_chip_select_n_out,
    input wire logic cmd_activate_out,
    input wire logic cmd_read_out,
    input wire logic cmd_write_out
);
    logic [HOST_AW-1:0] addr_ff;

    // Address of the request in flight
    always_ff @(posedge clock_in) begin
        if (req_valid_in && req_ready_out) begin
            addr_ff <= req_addr_in;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    sequence s_take;
        req_valid_in && req_ready_out;
    endsequence
    sequence s_access;
        cmd_activate_out ##1 (cmd_read_out || cmd_write_out);
    endsequence

    AST_ANSWER: assert property (s_take |=> cmd_activate_out != req_err_out)
        else $error("accepted request lacks one answer");
    AST_PAIR: assert property (cmd_activate_out |=> cmd_read_out != cmd_write_out)
        else $error("activate not followed by one access");
    AST_KIND: assert property (s_take ##1 cmd_activate_out |=> cmd_write_out == $past(req_write_in, 2))
        else $error("access kind differs from request");
    AST_BUSY: assert property (cmd_activate_out |-> !req_ready_out ##1 !req_ready_out ##1 req_ready_out)
        else $error("ready wrong during transfer");
    AST_CS_HOLD: assert property (s_access |-> $stable(chip_select_n_out) ##1 chip_select_n_out == 2'h3)
        else $error("select not held or not released");
    AST_ONE_CS: assert property (cmd_activate_out && density_in != SDAM_D16 |->
        $countones(chip_select_n_out) == 1)
        else $error("dense parts need one low select");
    AST_COL_ZERO: assert property ((cmd_read_out || cmd_write_out) |->
        !memory_address_bus_out[10])
        else $error("column bit 10 not zero");
    AST_COL_LOW: assert property (cmd_read_out || cmd_write_out |->
        memory_address_bus_out[7:0] == addr_ff[10:3])
        else $error("column low bits wrong");
    AST_ROW_BA0: assert property (cmd_activate_out |->
        internal_bank_select_0_out == addr_ff[11])
        else $error("row bank select 0 wrong");
    AST_ROW_BA1: assert property (cmd_activate_out && density_in == SDAM_D64_4B |->
        fourth_chip_select_n_out == addr_ff[12] && internal_bank_select_1_out == addr_ff[12])
        else $error("bank select 1 wrong");
    AST_ERR: assert property (req_err_out |->
        req_ready_out && !cmd_activate_out && chip_select_n_out == 2'h3)
        else $error("refusal drove the bus");
endmodule

bind sdam_ctrl sdam_checker i_chk (.clock_in(clock_in), .rstn_in(rstn_in), .density_in(density_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_ready_out(req_ready_out), .req_err_out(req_err_out), .memory_address_bus_out(memory_address_bus_out),
    .internal_bank_select_0_out(internal_bank_select_0_out), .internal_bank_select_1_out(internal_bank_select_1_out),
    .chip_select_n_out(chip_select_n_out), .fourth_chip_select_n_out(fourth_chip_select_n_out),
    .cmd_activate_out(cmd_activate_out), .cmd_read_out(cmd_read_out), .cmd_write_out(cmd_write_out));

//--- sdam_bank_model.sv
// Far-side bank model capturing the 17 pins of each address phase
`timescale 1ns/10ps
module sdam_bank_model (
    // Memory side
    input wire logic clock_in,
    input wire logic cmd_activate_in,
    input wire logic cmd_rw_in,
    input wire logic [16:0] pins_in,
    // Captured phases
    output logic [16:0] row_out,
    output logic [16:0] col_out
);
    // Row pins captured with activate, column pins with the access, all 17 pins
    always_ff @(posedge clock_in) begin
        if (cmd_activate_in) begin
            row_out <= pins_in;
        end
        if (cmd_rw_in) begin
            col_out <= pins_in;
        end
    end
endmodule

//--- sdam_ctrl_tb.sv
// Self-checking bench for the SDRAM address mapper
`timescale 1ns/10ps
module sdam_ctrl_tb;
    import sdam_pkg::*;
    logic clock_in, rstn_in, req_valid_in, req_write_in, req_ready_out, req_err_out, ba0, ba1, cs3_n, cs4_n;
    logic act, rd, wr_cmd;
    logic [HOST_AW-1:0] req_addr_in;
    sdam_density_t density_in;
    logic [2:0] banks_fitted_in;
    logic [MA_W-1:0] ma;
    logic [1:0] cs_n;
    logic [16:0] row_seen, col_seen;
    int n_errors = 0;
    int n_compared = 0;

    sdam_ctrl i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .density_in(density_in),
        .banks_fitted_in(banks_fitted_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
        .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .req_err_out(req_err_out),
        .memory_address_bus_out(ma), .internal_bank_select_0_out(ba0), .internal_bank_select_1_out(ba1),
        .chip_select_n_out(cs_n), .third_chip_select_n_out(cs3_n), .fourth_chip_select_n_out(cs4_n),
        .cmd_activate_out(act), .cmd_read_out(rd), .cmd_write_out(wr_cmd));
    sdam_bank_model i_model (.clock_in(clock_in), .cmd_activate_in(act), .cmd_rw_in(rd | wr_cmd),
        .pins_in({cs_n, ba1, ba0, cs4_n, cs3_n, ma}), .row_out(row_seen), .col_out(col_seen));

    // Clock and watchdog
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    initial begin
        repeat (3000) @(posedge clock_in);
        n_errors++;
        summarize();
    end

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // Expected pins: selects, bank selects, fourth, third, address
    function automatic logic [16:0] exp_pins(sdam_density_t d, logic [27:0] a, logic col);
        logic [12:0] m;
        logic [2:0] bk;
        logic b1;
        bk = d == SDAM_D16 ? a[27:25] : d == SDAM_D64_2B ? {2'h0, a[27]} : 3'h0;
        b1 = d[1] & a[12];
        case (d)
            SDAM_D16: m = col ? {3'h0, a[24:23], a[10:3]} : {2'h0, a[22:12]};
            SDAM_D64_2B: m = col ? {3'h0, a[26:25], a[10:3]} : a[24:12];
            SDAM_D64_4B: m = col ? {1'h0, a[27], 1'h0, a[26:25], a[10:3]} : {1'h0, a[24:13]};
            default: m = col ? {3'h0, a[27:26], a[10:3]} : a[25:13];
        endcase
        return {bk < 3'h2 ? ~(2'h1 << bk[0]) : 2'h3, b1, a[11],
            d == SDAM_D16 ? bk != 3'h3 : d == SDAM_D64_4B ? b1 : m[12], d == SDAM_D16 ? bk != 3'h2 : m[11], m[10:0]};
    endfunction

    // One request, called at a falling edge
    task automatic xfer(input logic [27:0] a, input logic wr, input logic err);
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_addr_in = a;
        for (int n = 0; n < 10 && req_ready_out !== 1'b1; n++) @(negedge clock_in);
        @(negedge clock_in);
        req_valid_in = 1'b0;
        check({14'h0, req_ready_out, req_err_out, act}, {14'h0, err, err, !err});
        if (err) begin
            @(negedge clock_in);
        end else begin
            @(negedge clock_in);
            check({14'h0, req_ready_out, rd, wr_cmd}, {14'h0, 1'b0, !wr, wr});
            @(negedge clock_in);
            check(row_seen, exp_pins(density_in, a, 1'b0));
            check(col_seen, exp_pins(density_in, a, 1'b1));
        end
    endtask

    // Every density, read then write, back to back
    task automatic t_map();
        logic [27:0] tbl [8] = '{28'h0D5A9F8, 28'h3AB5670, 28'h7F35C9A, 28'hE6A3D58,
            28'hFC6B2E5, 28'h5A93C78, 28'hB3C5A6D, 28'h4E1F7A2};
        banks_fitted_in = 3'h2; // Banks zero and one populated
        for (int d = 0; d < 4; d++) begin
            density_in = sdam_density_t'(d);
            @(negedge clock_in);
            xfer(tbl[2 * d], 1'b0, 1'b0);
            xfer(tbl[2 * d + 1], 1'b1, 1'b0);
        end
    endtask

    // Bank count limits and the top of the space
    task automatic t_limits();
        density_in = SDAM_D16;
        banks_fitted_in = 3'h7;
        @(negedge clock_in);
        xfer(28'h7FFFFF8, 1'b1, 1'b0);
        xfer(28'h4000010, 1'b0, 1'b0);
        xfer(28'h8000000, 1'b0, 1'b1);
        banks_fitted_in = 3'h0;
        xfer(28'h2000000, 1'b0, 1'b1);
        density_in = SDAM_D64_2B;
        banks_fitted_in = 3'h7;
        @(negedge clock_in);
        xfer(28'h8000008, 1'b1, 1'b0);
        density_in = SDAM_D256;
        @(negedge clock_in);
        xfer(28'hFFFFFFF, 1'b0, 1'b0);
    endtask

    initial begin
        rstn_in = 1'b0;
        req_valid_in = 1'b0;
        req_write_in = 1'b0;
        req_addr_in = 28'h0;
        density_in = SDAM_D16;
        banks_fitted_in = 3'h4;
        repeat (20) @(negedge clock_in);
        rstn_in = 1'b1;
        check({11'h0, cs_n, cs3_n, cs4_n, req_ready_out, act}, {11'h0, 6'h3E});
        t_map();
        t_limits();
        summarize();
    end
endmodule
